//--- verilog/move_exec_pkg.sv
/*
 Constants and types for the move and bank-literal execute block.
 Assumes the core delivers 16-bit instruction words and a four-phase cycle.
*/
// Function
// - Top bits 011 decode file-to-periph move
// - Any source byte written to destination 00h-1Eh
// - Bank literal goes to bank select low nibble
// - Bank select upper nibble keeps its value
// - Bank load recognised by upper byte 1011 1000
// - Phases: decode, read, process, write
package move_exec_pkg;
  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [2:0] OP_MOVE_TOP  = 3'h3;
  localparam logic [7:0] OP_BANK_HI   = 8'hB8;
  localparam int         OP_TOP_MSB   = 15;
  localparam int         OP_TOP_LSB   = 13;
  localparam int         DST_MSB      = 12;
  localparam int         DST_LSB      = 8;
  localparam int         SRC_MSB      = 7;
  localparam int         SRC_LSB      = 0;
  localparam int         LIT_MSB      = 3;
  localparam int         LIT_LSB      = 0;
  localparam int         OPC_HI_MSB   = 15;
  localparam int         OPC_HI_LSB   = 8;
  localparam int         BANK_UP_MSB  = 7;
  localparam int         BANK_UP_LSB  = 4;
  localparam logic [4:0] DST_MAX      = 5'h1E;
  localparam logic [7:0] BANK_RESET   = 8'h00;

  // ****************************************************************
  // Phase type
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_e;
endpackage : move_exec_pkg

//--- verilog/move_decode_if.sv
/*
 Decoded instruction fields carried from decoder to executor.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface move_decode_if;
  logic       is_move;
  logic       is_bank;
  logic [4:0] dst;
  logic [7:0] src;
  logic [3:0] lit;
  modport dec (output is_move, is_bank, dst, src, lit);
  modport exe (input is_move, is_bank, dst, src, lit);
endinterface : move_decode_if

//--- verilog/move_decoder.sv
/*
 Combinational decoder for the two instructions.
 Assumes the instruction word is stable through the cycle.
*/
`timescale 1ns/1ps
module move_decoder
  import move_exec_pkg::*;
(
  // Instruction
  input  wire logic [15:0] instr_in,
  // Decoded fields
  move_decode_if.dec       dec
);
  // ****************************************************************
  // Field extraction
  // ****************************************************************
  // Destinations above 1Eh are not legal, so reject them here
  assign dec.is_move = (instr_in[OP_TOP_MSB:OP_TOP_LSB] == OP_MOVE_TOP)
                     && (instr_in[DST_MSB:DST_LSB] <= DST_MAX);
  assign dec.is_bank = (instr_in[OPC_HI_MSB:OPC_HI_LSB] == OP_BANK_HI);
  assign dec.dst     = instr_in[DST_MSB:DST_LSB];
  assign dec.src     = instr_in[SRC_MSB:SRC_LSB];
  assign dec.lit     = instr_in[LIT_MSB:LIT_LSB];
endmodule : move_decoder

//--- verilog/move_exec.sv
/*
 Execute logic for the file-to-periph move and bank-literal load.
 Assumes the core gives one instruction word per four-phase cycle and a
 data memory with registered read data valid one clock after address.
 The upper nibble of the bank select register has no writer in this
 block; other instructions of the core own it.
*/
`timescale 1ns/1ps
module move_exec
  import move_exec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Instruction fetch
  input  wire logic [15:0] instr_in,
  input  wire logic        instr_valid_in,
  // Data memory
  input  wire logic [7:0]  rd_data_in,
  output logic      [7:0]  rd_addr_out,
  output logic             rd_en_out,
  output logic      [7:0]  wr_addr_out,
  output logic      [7:0]  wr_data_out,
  output logic             wr_en_out,
  // Bank select
  output logic      [7:0]  bank_select_reg_out,
  output logic             busy_out
);
  import move_exec_pkg::*;

  // Decoded view of the latched word
  move_decode_if dif();
  phase_e        phase;
  phase_e        next_phase;
  logic [15:0]   instr;
  logic          active;
  logic          take_now;
  logic          do_read;
  logic          do_write;
  logic          do_bank;
  logic [7:0]    next_bank;

  // Decoder looks only at the held word, never at the fetch bus
  move_decoder u_dec (
    .instr_in (instr),
    .dec      (dif)
  );

  // ****************************************************************
  // Phase sequencing
  // ****************************************************************
  // One instruction cycle is four phases, then back to Q1
  always_comb begin
    case (phase)
      PH_Q1:   next_phase = active ? PH_Q2 : PH_Q1;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  // Take only from an idle Q1 so a word never lands mid-cycle
  assign take_now = (phase == PH_Q1) && !active && instr_valid_in;

  // Latch instruction at Q1; held so decode stays stable all cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase  <= PH_Q1;
      instr  <= 16'h0000;
      active <= 1'b0;
    end else if (ce_in) begin
      phase <= next_phase;
      if (take_now) begin
        instr  <= instr_in;
        active <= 1'b1;
      end else if (phase == PH_Q4) begin
        active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Data path
  // ****************************************************************
  // Read strobe only for a legal move; refused words still burn the slot
  assign do_read   = active && (phase == PH_Q1) && dif.is_move;
  // Write strobe set at the Q3 edge so it stands through Q4
  assign do_write  = active && (phase == PH_Q3) && dif.is_move;
  // Bank literal lands on the Q4 edge
  assign do_bank   = active && (phase == PH_Q4) && dif.is_bank;
  // Upper nibble fed back so only the literal bits can move
  assign next_bank = {bank_select_reg_out[BANK_UP_MSB:BANK_UP_LSB], dif.lit};

  // Strobes last one clock; busy trails the internal active flag by one
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_en_out <= 1'b0;
      wr_en_out <= 1'b0;
      busy_out  <= 1'b0;
    end else if (ce_in) begin
      rd_en_out <= do_read;
      wr_en_out <= do_write;
      busy_out  <= active;
    end
  end

  // Source may be any of the 256 locations, so no range test here
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_addr_out <= 8'h00;
    end else if (ce_in && do_read) begin
      rd_addr_out <= dif.src;
    end
  end

  // Memory data must be valid by the Q3 edge; no capture register, so
  // the move costs no extra clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else if (ce_in && do_write) begin
      wr_addr_out <= {3'h0, dif.dst};
      wr_data_out <= rd_data_in;
    end
  end

  // Bank select only; neither instruction has any status flag to touch
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bank_select_reg_out <= BANK_RESET;
    end else if (ce_in && do_bank) begin
      bank_select_reg_out <= next_bank;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // All checks on the core clock; reset aborts any attempt in flight
  // Literal reaches the low nibble on the Q4 edge
  property p_bank_low;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && active && phase == PH_Q4 && dif.is_bank)
        |=> bank_select_reg_out[3:0] == $past(dif.lit);
  endproperty
  a_bank_low: assert property (p_bank_low) else $error("bank low wrong");

  // Upper nibble never moves while this block runs
  property p_bank_hi;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> bank_select_reg_out[7:4] == $past(bank_select_reg_out[7:4]);
  endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank high changed");

  // Writes only reach the low peripheral locations
  property p_wr_range;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_out |-> wr_addr_out <= {3'h0, DST_MAX};
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("dest out of range");

  // Q4 always wraps back to Q1
  property p_cycle;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && phase == PH_Q4) |=> phase == PH_Q1;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle not four phases");

  // Read and write never share a phase
  property p_order;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_out |-> !wr_en_out;
  endproperty
  a_order: assert property (p_order) else $error("read and write overlap");

  // Read strobe stands only in the read phase
  property p_rd_phase;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_out |-> phase == PH_Q2;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read outside Q2");

  // Write strobe stands only in the write phase
  property p_wr_phase;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_out |-> phase == PH_Q4;
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write outside Q4");

  // Read address is the source field of the held word
  property p_rd_src;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_out |-> rd_addr_out == dif.src;
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("read address not source");

  // Bank register only changes on a bank load
  property p_bank_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && do_bank) |=> $stable(bank_select_reg_out);
  endproperty
  a_bank_quiet: assert property (p_bank_quiet) else $error("bank changed idle");

  // A low enable holds the phase where it is
  property p_freeze;
    @(posedge clk_in) disable iff (!rst_n_in)
      !ce_in |=> $stable(phase);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved while frozen");

  // Refused words never start a read
  property p_refused;
    @(posedge clk_in) disable iff (!rst_n_in)
      (active && phase == PH_Q1 && !dif.is_move) |=> !rd_en_out;
  endproperty
  a_refused: assert property (p_refused) else $error("refused word read");

  // A write only happens inside a busy instruction slot
  property p_wr_busy;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_out |-> busy_out;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write outside slot");
endmodule : move_exec

//--- tb/tb_top.sv
/* Bench for move_exec: moves, refused moves, bank loads, freeze, reset.
   Assumes the package and the design files are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import move_exec_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic [15:0] instr_in = 16'h0000;
  logic        instr_valid_in = 1'b0;
  logic [7:0]  rd_data_in = 8'h00;
  logic [7:0]  rd_addr_out, wr_addr_out, wr_data_out, bank_select_reg_out, rd_cap;
  logic        rd_en_out, wr_en_out, busy_out;
  int          miscompares = 0, total_checks = 0, rd_seen, wr_seen, busy_seen;
  // 100 MHz clock
  always #5 clk_in = ~clk_in;
  move_exec u_move_exec (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .instr_in(instr_in), .instr_valid_in(instr_valid_in), .rd_data_in(rd_data_in),
    .rd_addr_out(rd_addr_out), .rd_en_out(rd_en_out), .wr_addr_out(wr_addr_out),
    .wr_data_out(wr_data_out), .wr_en_out(wr_en_out),
    .bank_select_reg_out(bank_select_reg_out), .busy_out(busy_out));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8
  // One instruction, then six falls; counts strobes so a stuck one shows
  task automatic run_instr(input logic [15:0] word, input logic [7:0] data);
    instr_in = word;
    instr_valid_in = 1'b1;
    rd_data_in = data;
    @(posedge clk_in);
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    rd_seen = 0;
    wr_seen = 0;
    busy_seen = 0;
    repeat (6) begin
      if (rd_en_out === 1'b1) begin
        rd_seen++;
        rd_cap = rd_addr_out;
      end
      if (wr_en_out === 1'b1) wr_seen++;
      if (busy_out === 1'b1) busy_seen++;
      @(negedge clk_in);
    end
  endtask : run_instr
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_move;
    run_instr(16'h65A7, 8'h5A);
    check8(8'(rd_seen), 8'h01);
    check8(rd_cap, 8'hA7);
    check8(8'(wr_seen), 8'h01);
    check8(wr_addr_out, 8'h05);
    check8(wr_data_out, 8'h5A);
    check8(8'(busy_seen), 8'h04);
    run_instr(16'h7EFF, 8'hC3);
    check8(wr_addr_out, 8'h1E);
    check8(wr_data_out, 8'hC3);
  endtask : test_move
  // Destination 1Fh and the other move direction must not write
  task automatic test_refused;
    run_instr(16'h7F10, 8'h99);
    check8(8'(wr_seen), 8'h00);
    check8(8'(rd_seen), 8'h00);
    check8(8'(busy_seen), 8'h04);
    check8(wr_addr_out, 8'h1E);
    run_instr(16'h4512, 8'h77);
    check8(8'(wr_seen), 8'h00);
  endtask : test_refused
  task automatic test_bank;
    run_instr(16'hB80F, 8'h00);
    check8(bank_select_reg_out, 8'h0F);
    run_instr(16'hB805, 8'h00);
    check8(bank_select_reg_out, 8'h05);
    check8(8'(wr_seen), 8'h00);
    run_instr(16'hB905, 8'h00);
    run_instr(16'h6312, 8'h44);
    check8(bank_select_reg_out, 8'h05);
    run_instr(16'hB8F3, 8'h00);
    check8(bank_select_reg_out, 8'h03);
  endtask : test_bank
  // Take a move, hold the enable low mid-instruction, then let it finish
  task automatic test_freeze;
    instr_in = 16'h6A3C;
    instr_valid_in = 1'b1;
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    ce_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check8({7'h00, rd_en_out}, 8'h00);
    check8(wr_addr_out, 8'h03);
    ce_in = 1'b1;
    run_instr(16'h4000, 8'h81);
    check8(rd_cap, 8'h3C);
    check8(8'(wr_seen), 8'h01);
    check8(wr_addr_out, 8'h0A);
    check8(wr_data_out, 8'h81);
  endtask : test_freeze
  // Reset while idle after the freeze run, then a load straight after release
  task automatic test_reset;
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    check8(bank_select_reg_out, BANK_RESET);
    check8(wr_addr_out, 8'h00);
    run_instr(16'hB806, 8'h00);
    check8(bank_select_reg_out, 8'h06);
  endtask : test_reset
  initial begin
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    check8(bank_select_reg_out, BANK_RESET);
    test_move();
    test_refused();
    test_bank();
    test_freeze();
    test_reset();
    test_done();
  end
endmodule : tb_top
